// ==== ahs_top.sv ====
// ahs_top: host serial interface of a sampling converter, register map with checksum
// assumes pins arrive asynchronously; sclk is sampled by mclk, far slower than mclk
`default_nettype none
module ahs_top
   import ahs_pkg::*;
(
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic cs_n_pin,
   input  wire logic sclk_pin,
   input  wire logic din_pin,
   input  wire logic sync_reset_n_pin,
   input  wire logic master_clock_input,
   input  wire logic frame_crc_en,
   output logic      dout,
   output logic      dout_oe,
   output logic      conversion_ready_n,
   output logic      frame_crc_error
);
   typedef struct packed {
      logic [1:0]  cs_s;
      logic [2:0]  sclk_s;
      logic [1:0]  din_s;
      logic [2:0]  sync_s;
      logic [2:0]  mck_s;
      logic [1:0]  crcen_s;
      ahs_phase_e  phase;
      logic [4:0]  bitcnt;
      logic [15:0] shin;
      logic [15:0] shout;
      logic [15:0] cmd;
      logic [15:0] wword;
      logic        rd_pend;
      logic [15:0] rxcrc;
      logic [15:0] txcrc;
      logic [15:0] checksum;
      logic [15:0] regcrc;
      logic [5:0]  sweep;
      logic        sweeping;
      logic        clearing;
      logic        dout;
      logic        dout_oe;
      logic [15:0] mck_cnt;
      logic [3:0]  rdy_cnt;
      logic        rdy_n;
      logic        crc_err;
   } ahs_state_s;

   ahs_state_s       s;
   ahs_state_s       next_s;
   logic             mem_we;
   logic [5:0]       mem_waddr;
   logic [15:0]      mem_wdata;
   logic [5:0]       mem_raddr;
   logic [15:0]      mem_rdata;

   ahs_regmem ahs_regmem_i (
      .mclk  (mclk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   function automatic logic [15:0] crc_word(input logic [15:0] crc, input logic [15:0] w);
      logic [15:0] c;
      c = crc;
      for (int i = 15; i >= 0; i--) begin
         c = ahs_crc_step(c, w[i]);
      end
      crc_word = c;
   endfunction

   logic cs_act;
   logic rise;
   logic fall;
   logic sync_fall;
   logic mck_rise;
   assign cs_act    = ~s.cs_s[1];
   assign rise      = s.sclk_s[1] & ~s.sclk_s[2];
   assign fall      = ~s.sclk_s[1] & s.sclk_s[2];
   assign sync_fall = ~s.sync_s[1] & s.sync_s[2];
   assign mck_rise  = s.mck_s[1] & ~s.mck_s[2];

   always_comb begin
      logic [15:0] w;
      logic        is_wr;
      logic        cmd_end;
      w         = '0;
      is_wr     = 1'b0;
      cmd_end   = cs_act && s.bitcnt == 5'd16 && s.phase == AHS_CMD;
      next_s    = s;
      mem_we    = 1'b0;
      mem_waddr = s.sweep;
      mem_wdata = '0;
      mem_raddr = s.sweep;
      // first flop of each synchroniser feeds only the second
      next_s.cs_s   = {s.cs_s[0], cs_n_pin};
      next_s.sclk_s = {s.sclk_s[1:0], sclk_pin};
      next_s.din_s  = {s.din_s[0], din_pin};
      next_s.sync_s = {s.sync_s[1:0], sync_reset_n_pin};
      next_s.mck_s  = {s.mck_s[1:0], master_clock_input};
      next_s.crcen_s = {s.crcen_s[0], frame_crc_en};

      // background sweep keeps the checksum current; clear sweep after reset
      if (s.clearing) begin
         mem_we = 1'b1;
         next_s.sweep = s.sweep + 6'd1;
         if (s.sweep == RSVD_ADDR) begin
            next_s.clearing = 1'b0;
         end
      end else if (cmd_end || s.rd_pend) begin
         // sweep pauses while a host read borrows the port, then re-reads its word
         mem_raddr = s.sweep - 6'd1;
      end else begin
         mem_raddr = s.sweep;
         if (s.sweeping) begin
            if (s.sweep != CHECKSUM_ADDR + 6'd1) begin
               next_s.regcrc = crc_word(s.regcrc, mem_rdata);
            end
         end
         next_s.sweeping = 1'b1;
         next_s.sweep = s.sweep + 6'd1;
         if (s.sweep == 6'd0 && s.sweeping) begin
            // last word folds in here while the seed restarts the next pass
            next_s.checksum = crc_word(s.regcrc, mem_rdata);
            next_s.regcrc   = CRC_SEED;
         end
      end

      // sample timing tracks the master clock; sync strobe restarts the period
      if (s.rdy_cnt != 4'h0) begin
         next_s.rdy_cnt = s.rdy_cnt - 4'h1;
      end
      // a new pulse wins over the countdown
      if (sync_fall) begin
         next_s.mck_cnt = '0;
      end else if (mck_rise) begin
         if (s.mck_cnt == 16'(SAMPLE_CYCLES / 64 - 1)) begin
            next_s.mck_cnt = '0;
            next_s.rdy_cnt = READY_PULSE;
         end else begin
            next_s.mck_cnt = s.mck_cnt + 16'd1;
         end
      end
      next_s.rdy_n = (s.rdy_cnt == 4'h0);

      // serial frame: command word, data word, crc word
      next_s.rd_pend = 1'b0;
      if (!cs_act) begin
         next_s.phase   = AHS_CMD;
         next_s.bitcnt  = '0;
         next_s.dout_oe = 1'b0;
         next_s.rxcrc   = CRC_SEED;
         next_s.txcrc   = CRC_SEED;
      end else begin
         next_s.dout_oe = 1'b1;
         // stored word arrives one cycle after the command, well before the next fall
         if (s.rd_pend && s.cmd[12:7] != CHECKSUM_ADDR) begin
            next_s.shout = mem_rdata;
         end
         if (rise && s.phase != AHS_DONE) begin
            next_s.shin   = {s.shin[14:0], s.din_s[1]};
            next_s.rxcrc  = ahs_crc_step(s.rxcrc, s.din_s[1]);
            next_s.bitcnt = s.bitcnt + 5'd1;
         end
         if (fall) begin
            next_s.dout  = s.shout[15];
            next_s.shout = {s.shout[14:0], 1'b0};
            next_s.txcrc = ahs_crc_step(s.txcrc, s.shout[15]);
         end
         if (s.bitcnt == 5'd16) begin
            next_s.bitcnt = '0;
            w = s.shin;
            case (s.phase)
               AHS_CMD: begin
                  next_s.cmd   = w;
                  next_s.phase = AHS_DATA;
                  mem_raddr    = w[12:7];
                  next_s.rd_pend = 1'b1;
                  if (w[12:7] == CHECKSUM_ADDR) begin
                     next_s.shout = s.checksum;
                  end
               end
               AHS_DATA: begin
                  is_wr = (s.cmd[15:13] == CMD_WRITE);
                  next_s.phase = AHS_CRC;
                  next_s.wword = w;
                  next_s.shout = s.txcrc;
                  next_s.cmd[0] = is_wr;
               end
               AHS_CRC: begin
                  next_s.phase = AHS_DONE;
                  // frame crc gates writes when enabled
                  next_s.crc_err = s.crcen_s[1] && (s.rxcrc != 16'h0000);
                  if (s.cmd[0] && s.cmd[12:7] != CHECKSUM_ADDR &&
                      !(s.crcen_s[1] && s.rxcrc != 16'h0000)) begin
                     mem_we    = 1'b1;
                     mem_waddr = s.cmd[12:7];
                     // reserved word stored as written; the host keeps it zero
                     mem_wdata = s.wword;
                  end
               end
               default: begin
                  next_s.phase = AHS_DONE;
               end
            endcase
         end
      end

      if (sys_rst) begin
         next_s          = '0;
         next_s.cs_s     = 2'b11;
         next_s.sclk_s   = '0;
         next_s.sync_s   = 3'b111;
         next_s.phase    = AHS_CMD;
         next_s.checksum = CHECKSUM_RESET;
         next_s.regcrc   = CRC_SEED;
         next_s.rxcrc    = CRC_SEED;
         next_s.txcrc    = CRC_SEED;
         next_s.clearing = 1'b1;
         next_s.rdy_n    = 1'b1;
         mem_we          = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      s <= next_s;
   end

   always_comb begin
      dout               = s.dout;
      dout_oe            = s.dout_oe;
      conversion_ready_n = s.rdy_n;
      frame_crc_error    = s.crc_err;
   end
endmodule
`default_nettype wire

// ==== ahs_pkg.sv ====
// ahs_pkg: register map, frame and timing constants of the host serial interface
// assumes a 40 MHz system clock and a 16-bit register word
`default_nettype none
package ahs_pkg;
   localparam int          REG_W          = 16;
   localparam int          ADDR_W         = 6;
   localparam int          NUM_REGS       = 64;
   localparam logic [5:0]  CHECKSUM_ADDR  = 6'h3E;
   localparam logic [5:0]  RSVD_ADDR      = 6'h3F;
   localparam logic [15:0] CHECKSUM_RESET = 16'h0000;
   localparam logic [15:0] RSVD_RESET     = 16'h0000;
   localparam logic [15:0] CRC_POLY       = 16'h1021;
   localparam logic [15:0] CRC_SEED       = 16'hFFFF;
   localparam logic [2:0]  CMD_READ       = 3'h5;
   localparam logic [2:0]  CMD_WRITE      = 3'h3;
   localparam int          CLK_HZ         = 40000000;
   localparam int          SAMPLE_PERIOD_NS = 125000;
   localparam int          SAMPLE_CYCLES  = SAMPLE_PERIOD_NS / (1000000000 / CLK_HZ);
   localparam logic [3:0]  READY_PULSE    = 4'h8;

   typedef enum logic [3:0] {
      AHS_CMD  = 4'b0001,
      AHS_DATA = 4'b0010,
      AHS_CRC  = 4'b0100,
      AHS_DONE = 4'b1000
   } ahs_phase_e;

   function automatic logic [15:0] ahs_crc_step(input logic [15:0] crc, input logic bit_in);
      logic fb;
      fb = crc[15] ^ bit_in;
      ahs_crc_step = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
   endfunction
endpackage
`default_nettype wire

// ==== ahs_regmem.sv ====
// ahs_regmem: 64 x 16 register store with registered read port
// assumes one write and one read per cycle, same clock
`default_nettype none
module ahs_regmem
   import ahs_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] waddr,
   input  wire logic [REG_W-1:0]  wdata,
   input  wire logic [ADDR_W-1:0] raddr,
   output logic      [REG_W-1:0]  rdata
);
   logic [REG_W-1:0] mem [NUM_REGS];

   // no reset: contents are written from zero by the controller's clear sweep
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// ==== ahs_top_sva.sv ====
// ahs_top_sva: port checks of the host serial interface
// assumes one mclk domain, bound into ahs_top
`default_nettype none
module ahs_top_sva (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic din_pin,
   input wire logic sync_reset_n_pin,
   input wire logic master_clock_input,
   input wire logic frame_crc_en,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic conversion_ready_n,
   input wire logic frame_crc_error
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // select sync lag is about 3 mclk, so allow 4
   AST_OE_OFF:
   assert property (cs_n_pin [*4] |-> !dout_oe) else $error("dout driven while deselected");
   AST_OE_ON:
   assert property ($rose(dout_oe) |-> !cs_n_pin) else $error("dout enabled without select");
   AST_RST_OUT:
   assert property ($fell(sys_rst) |-> !dout && !dout_oe && conversion_ready_n
      && !frame_crc_error) else $error("outputs not at reset level");
   AST_RDY_LEN:
   assert property ($fell(conversion_ready_n) |-> !conversion_ready_n [*8] ##1
      conversion_ready_n) else $error("ready pulse not 8 cycles");
   AST_RDY_GAP:
   assert property ($rose(conversion_ready_n) |-> conversion_ready_n [*8])
      else $error("ready pulses too close");
   AST_ERR_EN:
   // enable passes a two-flop synchroniser before the error flop
   assert property ($rose(frame_crc_error) |-> $past(frame_crc_en, 3))
      else $error("crc error while checking off");
   AST_ERR_QUIET:
   assert property ((!frame_crc_en [*3] ##0 !frame_crc_error) |=> !frame_crc_error)
      else $error("crc error set while disabled");
   AST_DOUT_HOLD:
   assert property (sclk_pin [*4] |-> $stable(dout)) else $error("dout moved on clock high");
   CV_RDY: cover property ($fell(conversion_ready_n));
   CV_ERR: cover property ($rose(frame_crc_error));
   CV_OE: cover property ($rose(dout_oe));
endmodule
bind ahs_top ahs_top_sva ahs_top_sva_i (.mclk(mclk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin),
   .sclk_pin(sclk_pin), .din_pin(din_pin), .sync_reset_n_pin(sync_reset_n_pin),
   .master_clock_input(master_clock_input), .frame_crc_en(frame_crc_en), .dout(dout),
   .dout_oe(dout_oe), .conversion_ready_n(conversion_ready_n),
   .frame_crc_error(frame_crc_error));
`default_nettype wire

// ==== ahs_host.sv ====
// ahs_host: host controller model, one select, clock and data
// assumes the bench runs one frame at a time
`default_nettype none
module ahs_host (
   input  wire logic mclk,
   input  wire logic dout,
   output logic      cs_n,
   output logic      sclk,
   output logic      din
);
   timeunit 1ns;
   timeprecision 1ps;
   logic bit_q = 1'b0;
   logic tog = 1'b0;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
   end
   // idle data line wanders so a stale bit is never taken
   always @(negedge mclk) tog <= ~tog;
   assign din = cs_n ? tog : bit_q;
   task automatic frame(input logic [47:0] w, output logic [15:0] rd);
      rd = 16'h0000;
      @(negedge mclk) cs_n = 1'b0;
      for (int i = 47; i >= 0; i--) begin
         bit_q = w[i];
         repeat (4) @(negedge mclk);
         sclk = 1'b1;
         if (i < 32 && i > 15) rd[i-16] = dout;
         repeat (4) @(negedge mclk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge mclk);
      cs_n = 1'b1;
      repeat (8) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== ahs_top_bench.sv ====
// ahs_top_bench: self-checking bench of the host serial interface
// assumes ahs_host as far side and the bound checker
`default_nettype none
module ahs_top_bench
   import ahs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        sync_n = 1'b1;
   logic        mci = 1'b0;
   logic        crc_en = 1'b0;
   wire logic   cs_n, sclk, din, dout, oe, rdy_n, crc_err, miso;
   int          error_cnt = 0;
   int          compares = 0;
   int          n;
   logic [15:0] rd, d, mem [64];
   logic [5:0]  a;
   // bench master clock runs at half mclk, so two mclk per counted edge
   localparam int SYNC_TO_RDY   = 2 * (SAMPLE_CYCLES / 64);
   localparam int ZERO_PHASE_CH = 0;
   initial forever #12.5 mclk = ~mclk;
   always @(negedge mclk) mci <= ~mci;
   assign miso = oe ? dout : 1'bz;
   ahs_top ahs_top_i (.mclk(mclk), .sys_rst(sys_rst), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .din_pin(din), .sync_reset_n_pin(sync_n), .master_clock_input(mci),
      .frame_crc_en(crc_en), .dout(dout), .dout_oe(oe), .conversion_ready_n(rdy_n),
      .frame_crc_error(crc_err));
   ahs_host ahs_host_i (.mclk(mclk), .dout(miso), .cs_n(cs_n), .sclk(sclk), .din(din));
   function automatic logic [15:0] regsum();
      logic [15:0] c;
      c = CRC_SEED;
      for (int i = 0; i < 64; i++)
         for (int b = 15; b >= 0; b--)
            if (i != 62) c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction
   function automatic logic [15:0] fcrc(input logic [31:0] x);
      logic [15:0] c;
      c = CRC_SEED;
      for (int b = 31; b >= 0; b--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ x[b]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] ad, input logic [15:0] v, input logic bad);
      ahs_host_i.frame({CMD_WRITE, ad, 7'h00, v, fcrc({CMD_WRITE, ad, 7'h00, v}) ^ {16{bad}}},
         rd);
   endtask
   task automatic rdr(input logic [5:0] ad);
      ahs_host_i.frame({CMD_READ, ad, 7'h00, 32'h0000_0000}, rd);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      mem = '{default: 16'h0000};
      void'($urandom(99505));
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
      // clear sweep must finish first
      repeat (200) @(negedge mclk);
      rdr(6'h3E);
      chk(rd, regsum());
      chk({15'h0000, oe}, 16'h0000);
      $display("test reset_map done");
      for (int k = 0; k < 4; k++) begin
         a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3D : 6'($urandom_range(61));
         d = 16'($urandom);
         wr(a, d, 1'b0);
         mem[a] = d;
         rdr(a);
         chk(rd, d);
         rdr(6'h3E);
         chk(rd, regsum());
      end
      wr(6'h3E, 16'hFFFF, 1'b0);
      rdr(6'h3E);
      chk(rd, regsum());
      wr(6'h3F, 16'h0000, 1'b0);
      rdr(6'h3F);
      chk(rd, 16'h0000);
      $display("test map_writes done");
      crc_en = 1'b1;
      wr(a, ~d, 1'b1);
      chk({15'h0000, crc_err}, 16'h0001);
      crc_en = 1'b0;
      rdr(a);
      chk(rd, d);
      crc_en = 1'b1;
      wr(a, ~d, 1'b0);
      chk({15'h0000, crc_err}, 16'h0000);
      mem[a] = ~d;
      crc_en = 1'b0;
      rdr(a);
      chk(rd, ~d);
      rdr(6'h3E);
      chk(rd, regsum());
      $display("test bad_crc done");
      // strobe well clear of a free-running pulse so an ignored strobe shows
      for (n = 0; n < 1000 && rdy_n !== 1'b0; n++) @(negedge mclk);
      chk({15'h0000, rdy_n}, 16'h0000);
      repeat (20) @(negedge mclk);
      sync_n = 1'b0;
      repeat (4) @(negedge mclk);
      sync_n = 1'b1;
      for (n = 0; n < 1000 && rdy_n !== 1'b0; n++) @(negedge mclk);
      chk({15'h0000, rdy_n}, 16'h0000);
      chk({15'h0000, n >= SYNC_TO_RDY - 8 && n <= SYNC_TO_RDY + 4}, 16'h0001);
      $display("test sync_ready done, zero-phase channel %0d", ZERO_PHASE_CH);
      tally_and_finish();
   end
endmodule
`default_nettype wire
